// >>> rtl/bsp_pkg.sv
package bsp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ      = 25_000_000;
  localparam int CLK_PER_US  = CLK_HZ / 1_000_000;
  localparam int T_EN_US     = 1000;
  localparam int T_SS_US     = 3000;
  localparam int T_RACT_US   = 3000;
  localparam int T_HIC_US    = 5500;
  localparam int T_FILT_US   = 20;
  localparam int EN_CYC      = T_EN_US * CLK_PER_US;
  localparam int SS_CYC      = T_SS_US * CLK_PER_US;
  localparam int RACT_CYC    = T_RACT_US * CLK_PER_US;
  localparam int HIC_CYC     = T_HIC_US * CLK_PER_US;
  localparam int FILT_CYC    = T_FILT_US * CLK_PER_US;
  localparam int OSC_HZ      = 2_100_000;
  localparam int OSC_CYC     = CLK_HZ / OSC_HZ;
  localparam int SYNC_MIN_HZ = 1_900_000;
  localparam int SYNC_MAX_HZ = 2_300_000;
  localparam int SYNC_PER_LO = CLK_HZ / SYNC_MAX_HZ;
  localparam int SYNC_PER_HI = (CLK_HZ + SYNC_MIN_HZ - 1) / SYNC_MIN_HZ;
  localparam int LOCK_EDGES  = 4;
  localparam int VALLEY_MAX  = 64;
  localparam int CNT_W       = 18;
  localparam int REF_W       = 10;
  localparam int SS_STEP     = SS_CYC / (2 ** REF_W);

  // ****************************************************************
  // Registers
  // ****************************************************************
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_HICNT  = 4'h8;
  localparam int          CTRL_EN    = 0;
  localparam logic        CTRL_RST   = 1'b1;
  localparam int          ST_STATE   = 0;
  localparam int          ST_FLAG    = 3;
  localparam int          ST_PIN     = 4;
  localparam int          ST_LOCK    = 5;
  localparam int          ST_FORCED_PWM_SELECT    = 6;

  typedef enum logic [2:0] {
    BSP_OFF    = 3'b000,
    BSP_DELAY  = 3'b001,
    BSP_SOFT   = 3'b010,
    BSP_RUN    = 3'b011,
    BSP_HICCUP = 3'b100
  } bsp_state_t;

endpackage

// >>> rtl/bsp_sync_lock.sv
`timescale 1ns/1ps
`default_nettype none
module bsp_sync_lock
  import bsp_pkg::*;
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  // Synchronised sync level
  input  wire logic i_sync_lvl,
  // Lock result
  output logic      o_edge,
  output logic      o_locked
);

  logic       prev_q;
  logic [4:0] per_q;
  logic [2:0] good_q;
  logic       edge_q;
  logic       lock_q;
  logic       rise;
  logic       in_rng;

  assign rise   = i_sync_lvl & ~prev_q;
  assign in_rng = (per_q >= 5'(SYNC_PER_LO - 1)) &&
                  (per_q <= 5'(SYNC_PER_HI - 1));
  assign o_edge   = edge_q;
  assign o_locked = lock_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      prev_q <= 1'b0;
      per_q  <= 5'h0;
    end else begin
      prev_q <= i_sync_lvl;
      if (rise) begin
        per_q <= 5'h0;
      end else if (per_q != 5'h1f) begin
        per_q <= per_q + 5'h1;
      end
    end
  end

  // A grounded input drops the lock once more than SYNC_PER_HI clocks pass without an edge, and an out-of-range
  // edge drops it at once; the internal oscillator then restarts from zero, so a switching cycle is missed.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      good_q <= 3'h0;
      lock_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      edge_q <= rise & lock_q;
      if (per_q > 5'(SYNC_PER_HI)) begin
        good_q <= 3'h0;
        lock_q <= 1'b0;
      end else if (rise) begin
        if (!in_rng) begin
          good_q <= 3'h0;
          lock_q <= 1'b0;
        end else if (good_q == 3'(LOCK_EDGES)) begin
          lock_q <= 1'b1;
        end else begin
          good_q <= good_q + 3'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/bsp_sequencer.sv
// Overview of operation
// - Release flag after output good 3 ms.
// - Pull flag low whenever converter disabled.
// - Wait 1 ms after enable before ramp.
// - Ramp internal reference over fixed 3 ms.
// - Soft start runs automatic, ignores mode pin.
// - Start into pre-biased output without discharging.
// - Valley trip skips cycle, low side stays.
// - Over 64 valley trips: both off 5.5 ms.
// - After hiccup restart soft start, recount.
// - Two trip-free cycles clear valley counter.
// - Peak limit ends high-side on-time immediately.
// - Forced PWM: negative limit ends low side.
// - Automatic mode: zero-cross ends low side.
// - Sync rising edge starts high-side on-time.
// - Locked sync replaces oscillator, foldback unchanged.
// - Locked sync forces forced-PWM continuous conduction.
// - Glitch filter ignores short output excursions.
// - Mode pin high disables skipping, emulation.
`timescale 1ns/1ps
`default_nettype none
module bsp_sequencer
  import bsp_pkg::*;
#(
  parameter logic [CNT_W-1:0] P_EN_CYC   = CNT_W'(EN_CYC),
  parameter logic [CNT_W-1:0] P_SS_STEP  = CNT_W'(SS_STEP),
  parameter logic [CNT_W-1:0] P_RACT_CYC = CNT_W'(RACT_CYC),
  parameter logic [CNT_W-1:0] P_HIC_CYC  = CNT_W'(HIC_CYC)
)(
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_resetn,
  // Avalon-MM slave
  input  wire logic [3:0]       i_avs_address,
  input  wire logic             i_avs_read,
  input  wire logic             i_avs_write,
  input  wire logic [31:0]      i_avs_writedata,
  output logic      [31:0]      o_avs_readdata,
  output logic                  o_avs_waitrequest,
  // Host pins
  input  wire logic             i_enable,
  input  wire logic             i_forced_pwm_select,
  input  wire logic             i_sync_clk,
  input  wire logic             i_rst_flag_in,
  output logic                  o_rst_flag_out,
  output logic                  o_rst_flag_oe,
  // Comparators
  input  wire logic             i_valley_current_limit,
  input  wire logic             i_peak_current_limit,
  input  wire logic             i_negative_current_limit,
  input  wire logic             i_zero_cross_limit,
  input  wire logic             i_pwm_end,
  input  wire logic             i_pfm_skip,
  input  wire logic             i_foldback_hold,
  input  wire logic             i_pg_ok,
  // Power stage
  output logic                  o_hs_on,
  output logic                  o_ls_on,
  output logic      [REF_W-1:0] o_ss_ref
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NIN = 12;
  logic [NIN-1:0] meta_q;
  logic [NIN-1:0] sync_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {i_enable, i_forced_pwm_select, i_sync_clk, i_rst_flag_in,
                 i_valley_current_limit, i_peak_current_limit,
                 i_negative_current_limit, i_zero_cross_limit,
                 i_pwm_end, i_pfm_skip, i_foldback_hold, i_pg_ok};
      sync_q <= meta_q;
    end
  end

  logic en_s, forced_pwm_select_s, sync_s, pin_s, valley_s, peak_s;
  logic neg_s, zc_s, pwm_end_s, skip_s, fold_s, pg_s;
  assign {en_s, forced_pwm_select_s, sync_s, pin_s, valley_s, peak_s,
          neg_s, zc_s, pwm_end_s, skip_s, fold_s, pg_s} = sync_q;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic        ack_q;
  logic        ctrl_en_q;
  logic [31:0] rdata_q;
  logic [7:0]  hic_num_q;
  logic        flag_q;
  logic        locked;
  logic        forced_pwm_select_eff;
  bsp_state_t  state_q;

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign o_avs_readdata    = rdata_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ctrl_en_q <= CTRL_RST;
    end else if (i_avs_write && ack_q && i_avs_address == REG_CTRL) begin
      ctrl_en_q <= i_avs_writedata[CTRL_EN];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_avs_read && !ack_q) begin
      rdata_q <= 32'h0000_0000;
      case (i_avs_address)
        REG_CTRL: begin
          rdata_q[CTRL_EN] <= ctrl_en_q;
        end
        REG_STATUS: begin
          rdata_q[ST_STATE +: 3] <= state_q;
          rdata_q[ST_FLAG]       <= flag_q;
          rdata_q[ST_PIN]        <= pin_s;
          rdata_q[ST_LOCK]       <= locked;
          rdata_q[ST_FORCED_PWM_SELECT]       <= forced_pwm_select_eff;
        end
        REG_HICNT: begin
          rdata_q[7:0] <= hic_num_q;
        end
        default: begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // Switching clock
  // ****************************************************************
  logic       sync_edge;
  logic [3:0] osc_q;
  logic       pend_q;
  logic       src;
  logic       cyc_start;

  bsp_sync_lock u_lock (
    .i_ref_clk  (i_ref_clk),
    .i_resetn   (i_resetn),
    .i_sync_lvl (sync_s),
    .o_edge     (sync_edge),
    .o_locked   (locked)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn || locked) begin
      osc_q <= 4'h0;
    end else if (osc_q == 4'(OSC_CYC - 1)) begin
      osc_q <= 4'h0;
    end else begin
      osc_q <= osc_q + 4'h1;
    end
  end

  // Foldback only delays the start; the source itself is unchanged.
  assign src       = locked ? sync_edge
                            : (osc_q == 4'(OSC_CYC - 1));
  assign cyc_start = (src | pend_q) & ~fold_s;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= (src | pend_q) & fold_s;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic             en_all;
  logic             sw_en;
  logic             hic_go;
  logic [CNT_W-1:0] cnt_q;
  logic [REF_W-1:0] ref_q;
  logic [6:0]       vcnt_q;
  logic             miss_q;

  assign en_all   = en_s & ctrl_en_q;
  assign sw_en    = (state_q == BSP_SOFT) || (state_q == BSP_RUN);
  assign forced_pwm_select_eff = (state_q == BSP_RUN) && (forced_pwm_select_s || locked);
  assign hic_go   = sw_en && cyc_start && valley_s &&
                    (vcnt_q == 7'(VALLEY_MAX));
  assign o_ss_ref = ref_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state_q <= BSP_OFF;
      cnt_q   <= '0;
      ref_q   <= '0;
    end else if (!en_all) begin
      state_q <= BSP_OFF;
      ref_q   <= '0;
    end else begin
      case (state_q)
        BSP_OFF: begin
          state_q <= BSP_DELAY;
          cnt_q   <= P_EN_CYC - CNT_W'(1);
        end
        BSP_DELAY: begin
          if (cnt_q == '0) begin
            state_q <= BSP_SOFT;
            cnt_q   <= P_SS_STEP - CNT_W'(1);
            ref_q   <= '0;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        BSP_SOFT: begin
          if (hic_go) begin
            state_q <= BSP_HICCUP;
            cnt_q   <= P_HIC_CYC - CNT_W'(1);
          end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else if (ref_q == '1) begin
            state_q <= BSP_RUN;
          end else begin
            ref_q <= ref_q + REF_W'(1);
            cnt_q <= P_SS_STEP - CNT_W'(1);
          end
        end
        BSP_RUN: begin
          if (hic_go) begin
            state_q <= BSP_HICCUP;
            cnt_q   <= P_HIC_CYC - CNT_W'(1);
          end
        end
        BSP_HICCUP: begin
          ref_q <= '0;
          if (cnt_q == '0) begin
            state_q <= BSP_SOFT;
            cnt_q   <= P_SS_STEP - CNT_W'(1);
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        default: begin
          state_q <= BSP_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      hic_num_q <= 8'h00;
    end else if (hic_go && hic_num_q != 8'hff) begin
      hic_num_q <= hic_num_q + 8'h01;
    end
  end

  // Counts switching cycles, not reference clocks, so the limit does
  // not depend on whether the oscillator or the sync input is in use.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn || !sw_en || hic_go) begin
      vcnt_q <= 7'h00;
      miss_q <= 1'b0;
    end else if (cyc_start) begin
      if (valley_s) begin
        vcnt_q <= vcnt_q + 7'h01;
        miss_q <= 1'b0;
      end else begin
        miss_q <= 1'b1;
        if (miss_q) begin
          vcnt_q <= 7'h00;
        end
      end
    end
  end

  // ****************************************************************
  // Power stage commands
  // ****************************************************************
  // The high side only turns on at a cycle start, where the low side
  // is cleared on the same edge, so both are never on together.
  // During soft start the low side ends at zero cross, so a pre-biased
  // output is never pulled down, and the skip input holds off pulses
  // until the ramp passes the existing output level.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn || !sw_en || hic_go) begin
      o_hs_on <= 1'b0;
      o_ls_on <= 1'b0;
    end else if (cyc_start) begin
      if (valley_s) begin
        o_hs_on <= 1'b0;
        o_ls_on <= 1'b1;
      end else if (!forced_pwm_select_eff && skip_s) begin
        o_hs_on <= 1'b0;
        o_ls_on <= 1'b0;
      end else begin
        o_hs_on <= 1'b1;
        o_ls_on <= 1'b0;
      end
    end else if (o_hs_on && (peak_s || pwm_end_s)) begin
      o_hs_on <= 1'b0;
      o_ls_on <= 1'b1;
    end else if (o_ls_on && !valley_s &&
                 (forced_pwm_select_eff ? neg_s : zc_s)) begin
      o_ls_on <= 1'b0;
    end
  end

  // ****************************************************************
  // Reset flag
  // ****************************************************************
  logic [CNT_W-1:0] bad_q;
  logic             pg_f_q;
  logic [CNT_W-1:0] rel_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      bad_q  <= '0;
      pg_f_q <= 1'b0;
    end else if (pg_s) begin
      bad_q  <= '0;
      pg_f_q <= 1'b1;
    end else if (bad_q == CNT_W'(FILT_CYC - 1)) begin
      pg_f_q <= 1'b0;
    end else begin
      bad_q <= bad_q + CNT_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn || !en_all || !pg_f_q || state_q == BSP_OFF) begin
      rel_q  <= '0;
      flag_q <= 1'b0;
    end else if (rel_q == P_RACT_CYC - CNT_W'(1)) begin
      flag_q <= 1'b1;
    end else begin
      rel_q <= rel_q + CNT_W'(1);
    end
  end

  assign o_rst_flag_out = 1'b0;
  assign o_rst_flag_oe  = ~flag_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  release_delay_a: assert property (
    $rose(flag_q) |-> $past(rel_q) == P_RACT_CYC - CNT_W'(1))
    else $error("reset flag released early");
  flag_off_a: assert property (
    !en_all |=> o_rst_flag_oe)
    else $error("flag not driven low while disabled");
  turn_on_delay_a: assert property (
    ($past(state_q) == BSP_DELAY && state_q == BSP_SOFT) |->
    $past(cnt_q) == '0)
    else $error("soft start began before the delay ended");
  ss_auto_a: assert property (
    (state_q == BSP_SOFT && cyc_start && !valley_s && skip_s &&
     forced_pwm_select_s) |=> !o_hs_on)
    else $error("mode pin obeyed during soft start");
  valley_skip_a: assert property (
    (sw_en && cyc_start && valley_s && !hic_go) |=> !o_hs_on && o_ls_on)
    else $error("cycle not skipped on valley trip");
  hiccup_off_a: assert property (
    state_q == BSP_HICCUP |-> !o_hs_on && !o_ls_on)
    else $error("switch on during hiccup wait");
  hiccup_exit_a: assert property (
    ($past(state_q) == BSP_HICCUP && state_q != BSP_HICCUP) |->
    state_q == BSP_SOFT || state_q == BSP_OFF)
    else $error("hiccup left without soft start");
  valley_clear_a: assert property (
    (sw_en && !hic_go && cyc_start && !valley_s && miss_q) |=>
    vcnt_q == 7'h00)
    else $error("valley counter not cleared");
  peak_end_a: assert property (
    (o_hs_on && peak_s && !cyc_start) |=> !o_hs_on)
    else $error("high side not ended at peak limit");
  neg_end_a: assert property (
    (o_ls_on && forced_pwm_select_eff && neg_s && !valley_s && !cyc_start) |=>
    !o_ls_on ##1 (!o_ls_on || $past(cyc_start)))
    else $error("low side kept on past negative limit");
  zc_end_a: assert property (
    (o_ls_on && !forced_pwm_select_eff && zc_s && !valley_s && !cyc_start) |=>
    !o_ls_on)
    else $error("low side kept on past zero cross");
  glitch_filter_a: assert property (
    $fell(pg_f_q) |-> $past(bad_q) == CNT_W'(FILT_CYC - 1))
    else $error("flag path tripped by short excursion");

endmodule
`default_nettype wire

// >>> test/bsp_power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module bsp_power_stage_model (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  // Switch commands and load
  input  wire logic       i_hs_on,
  input  wire logic       i_ls_on,
  input  wire logic       i_overload,
  input  wire logic [5:0] i_target,
  // Comparator results
  output logic            o_valley,
  output logic            o_peak,
  output logic            o_neg,
  output logic            o_zc,
  output logic            o_pwm_end
);
  // ****************************************************************
  // Inductor current
  // ****************************************************************
  int cur_q;

  // The floor keeps a long short-circuit run from winding the current far
  // below zero, which would stall recovery for thousands of cycles.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      cur_q <= 0;
    end else if (i_hs_on) begin
      cur_q <= cur_q + 4;
    end else if (i_ls_on && cur_q > -60) begin
      cur_q <= cur_q - 4;
    end else if (cur_q != 0) begin
      cur_q <= (cur_q > 0) ? cur_q - 1 : cur_q + 1;
    end
  end

  assign o_valley  = i_overload | (cur_q > 40);
  assign o_peak    = cur_q >= 24;
  assign o_pwm_end = cur_q >= int'(i_target);
  assign o_neg     = cur_q <= -8;
  assign o_zc      = cur_q <= 0;
endmodule
`default_nettype wire

// >>> test/buck_sequencer_protection_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  n_fail++; $display("unexpected %s: expected %0h seen %0h", nm, ex, gt); \
  end end
module buck_sequencer_protection_tb;
  import bsp_pkg::*;
  localparam int EN_T   = 20;
  localparam int STEP_T = 2;
  localparam int RACT_T = 30;
  localparam int HIC_T  = 40;
  localparam logic [31:0] ST_M = 32'h0000_007F;
  logic clk = 1'b0, rstn = 1'b0, en = 1'b0, forced_pwm_select = 1'b0, sync = 1'b0;
  logic pg = 1'b0, ovl = 1'b0, rd = 1'b0, wr = 1'b0, sync_on = 1'b0;
  logic chk_sync = 1'b0, hs_d = 1'b0, skip = 1'b0, fold = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000, seed = 32'h0001_7BB1, q;
  logic [5:0]  tgt = 6'h04;
  logic [31:0] rdata;
  logic        waitreq, oe, fout, hs, ls, vly, pk, ng, zc, pe;
  logic [REF_W-1:0] ss_ref;
  int n_fail = 0, total_checks = 0, cyc = 0, since_sync = 0, sph = 0;
  int run_pk = 0, run_ng = 0, run_zc = 0, max_pk = 0, max_ng = 0;
  int max_zc = 0, n_hs = 0;

  always #20 clk = ~clk;

  bsp_sequencer #(.P_EN_CYC(CNT_W'(EN_T)), .P_SS_STEP(CNT_W'(STEP_T)),
    .P_RACT_CYC(CNT_W'(RACT_T)), .P_HIC_CYC(CNT_W'(HIC_T))) dut (
    .i_ref_clk(clk), .i_resetn(rstn), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_enable(en), .i_forced_pwm_select(forced_pwm_select), .i_sync_clk(sync),
    .i_rst_flag_in(~oe | fout), .o_rst_flag_out(fout), .o_rst_flag_oe(oe),
    .i_valley_current_limit(vly), .i_peak_current_limit(pk),
    .i_negative_current_limit(ng), .i_zero_cross_limit(zc),
    .i_pwm_end(pe), .i_pfm_skip(skip), .i_foldback_hold(fold),
    .i_pg_ok(pg), .o_hs_on(hs), .o_ls_on(ls), .o_ss_ref(ss_ref));

  bsp_power_stage_model stage (.i_ref_clk(clk), .i_resetn(rstn),
    .i_hs_on(hs), .i_ls_on(ls), .i_overload(ovl), .i_target(tgt),
    .o_valley(vly), .o_peak(pk), .o_neg(ng), .o_zc(zc), .o_pwm_end(pe));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic [31:0] st(input logic [2:0] s, input logic l,
                                     input logic f, input logic r);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[2:0] = s;
    v[ST_FLAG] = r;
    v[ST_PIN] = r;
    v[ST_LOCK] = l;
    v[ST_FORCED_PWM_SELECT] = f;
    return v;
  endfunction

  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_reg(input logic [3:0] a, input logic [31:0] m,
                         input logic [31:0] ex, input string nm);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    `CHK(nm, ex, r & m)
  endtask

  task automatic hiccup(input int n);
    int t, off, bad;
    t = 0;
    off = 0;
    bad = 0;
    ovl <= 1'b1;
    while (t < 800 && !(t > 30 && hs === 1'b0 && ls === 1'b0)) begin
      @(posedge clk);
      t++;
      bad += (t > 30 && hs !== 1'b0);
    end
    `CHK("trip span", 1'b1, t >= 692 && t <= 746)
    `CHK("skipped starts", 0, bad)
    while (off < 100 && hs === 1'b0 && ls === 1'b0) begin
      @(posedge clk);
      off++;
    end
    `CHK("wait length", 1'b1, off >= HIC_T - 2 && off <= HIC_T + 14)
    `CHK("ramp restart", 1'b1, ss_ref < 10'h010)
    chk_reg(REG_HICNT, 32'h0000_00FF, 32'(n), "hiccup count");
  endtask

  // ****************************************************************
  // Monitors, load and sync source
  // ****************************************************************
  always @(posedge clk) begin
    cyc++;
    since_sync++;
    seed = xs(seed);
    tgt <= {1'b0, seed[4:0]} + 6'h04;
    run_pk = (pk && hs) ? run_pk + 1 : 0;
    run_ng = (ng && ls) ? run_ng + 1 : 0;
    run_zc = (zc && ls) ? run_zc + 1 : 0;
    max_pk = (run_pk > max_pk) ? run_pk : max_pk;
    max_ng = (run_ng > max_ng) ? run_ng : max_ng;
    max_zc = (run_zc > max_zc) ? run_zc : max_zc;
    if (chk_sync && hs && !hs_d) begin
      `CHK("sync to start", 1'b1, since_sync inside {[3:5]})
    end
    n_hs += (hs && !hs_d);
    hs_d = hs;
    if (sync_on) begin
      sph = (sph == 5) ? 0 : sph + 1;
      if (sph == 0) begin
        sync <= ~sync;
        since_sync = sync ? since_sync : 0;
      end
    end else begin
      sync <= 1'b0;
    end
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int t, t_ss, t_rel, t_top, bad, sk;
    t_ss = -1;
    sk = -1;
    t_rel = -1;
    t_top = -1;
    bad = 0;
    tick(20);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK("flag pulled", 1'b1, oe)
    chk_reg(REG_CTRL, 32'h0000_0001, 32'h0000_0001, "ctrl reset");
    chk_reg(4'hC, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    bus(1'b1, REG_STATUS, 32'hFFFF_FFFF, q);
    chk_reg(REG_STATUS, ST_M, st(BSP_OFF, 0, 0, 0), "off");
    pg <= 1'b1;
    forced_pwm_select <= 1'b1;
    en <= 1'b1;
    max_zc = 0;
    for (t = 1; t < 2400 && t_top < 0; t++) begin
      @(posedge clk);
      if (t_ss < 0 && ss_ref !== '0) t_ss = t;
      if (t_ss < 0 && hs !== 1'b0) bad++;
      if (t_rel < 0 && oe === 1'b0) t_rel = t;
      if (ss_ref === '1) t_top = t;
      skip <= (t >= 100 && t < 400);
      if (t == 160) n_hs = 0;
      if (t == 400) sk = n_hs;
    end
    `CHK("skip in soft", 0, sk)
    `CHK("turn-on delay", 1'b1, t_ss inside {[EN_T+2:EN_T+8]})
    `CHK("idle in delay", 0, bad)
    `CHK("ramp time", 1'b1, t_top - t_ss inside {[2042:2046]})
    `CHK("flag release", 1'b1, t_rel inside {[RACT_T:RACT_T+8]})
    `CHK("auto in soft", 1'b1, max_zc <= 4)
    tick(10);
    max_zc = 0;
    max_ng = 0;
    chk_reg(REG_STATUS, ST_M, st(BSP_RUN, 0, 1, 1), "forced_pwm_select");
    skip <= 1'b1;
    n_hs = 0;
    tick(300);
    `CHK("no emulation", 1'b1, max_zc >= 5)
    `CHK("negative stop", 1'b1, max_ng <= 4)
    `CHK("skip ignored", 1'b1, n_hs >= 5)
    skip <= 1'b0;
    forced_pwm_select <= 1'b0;
    tick(20);
    max_zc = 0;
    tick(300);
    `CHK("zero cross stop", 1'b1, max_zc <= 4)
    bad = 0;
    pg <= 1'b0;
    for (t = 0; t < 100; t++) begin
      @(posedge clk);
      bad += (oe !== 1'b0);
    end
    `CHK("short dip", 0, bad)
    pg <= 1'b1;
    tick(20);
    pg <= 1'b0;
    tick(560);
    `CHK("long dip", 1'b1, oe)
    pg <= 1'b1;
    tick(RACT_T - 4);
    `CHK("release held", 1'b1, oe)
    tick(14);
    `CHK("release again", 1'b0, oe)
    for (t = 0; t < 5; t++) begin
      seed = xs(seed);
      ovl <= 1'b1;
      tick(11 * (40 + int'(seed[3:0]) % 12));
      ovl <= 1'b0;
      tick(50);
    end
    chk_reg(REG_HICNT, 32'h0000_00FF, 32'h0000_0000, "no hiccup");
    hiccup(1);
    hiccup(2);
    ovl <= 1'b0;
    tick(2400);
    sync_on <= 1'b1;
    tick(96);
    chk_reg(REG_STATUS, ST_M, st(BSP_RUN, 1, 1, 1), "lock");
    chk_sync = 1'b1;
    tick(200);
    chk_sync = 0;
    fold <= 1'b1;
    tick(20);
    n_hs = 0;
    tick(80);
    `CHK("foldback hold", 0, n_hs)
    fold <= 1'b0;
    sync_on <= 1'b0;
    tick(40);
    chk_reg(REG_STATUS, ST_M, st(BSP_RUN, 0, 0, 1), "unlock");
    `CHK("peak stop", 1'b1, max_pk <= 4)
    bus(1'b1, REG_CTRL, 32'h0000_0000, q);
    tick(3);
    `CHK("soft disable", 1'b1, oe)
    `CHK("stage off", 2'b00, {hs, ls})
    chk_reg(REG_CTRL, 32'h0000_0001, 32'h0000_0000, "ctrl write");
    complete_run();
  end
endmodule
`default_nettype wire
